// ### rtl/fsq_host.sv
// Host-side command sequencer: turns user operations into flash bus write/read cycles.
// Assumes flash pins synchronous to ref_clk; the board resolves dq from dq_oe.
`timescale 1ns/10ps
module fsq_host #(
  parameter int COLL_LIMIT = fsq_pkg::COLL_CYC,
  parameter bit BYTE_MODE = 1'b0
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // User command port
  input wire logic cmd_valid,
  input wire fsq_pkg::fsq_op_t cmd_op,
  input wire logic [21:0] cmd_addr,
  input wire logic [15:0] cmd_data,
  output logic cmd_ack,
  output logic cmd_rej,
  output logic rd_valid,
  output logic [15:0] rd_data,
  output logic busy,
  output logic ssr_mode,
  output logic bypass_mode,
  // Flash pins
  output fsq_pkg::fsq_pins_t fl,
  input wire logic [15:0] dq_in,
  input wire logic ready_busy_in,
  output logic accel_hv_en,
  output logic byte_mode_n
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  fsq_pkg::fsq_state_t state_reg, state_next;
  fsq_pkg::fsq_op_t op_reg, op_next;
  fsq_pkg::fsq_pins_t fl_reg, fl_next;
  logic [2:0] idx_reg, idx_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [15:0] coll_reg;
  logic [21:0] addr_reg;
  logic [15:0] data_reg;
  logic ssr_reg, byp_reg, accel_reg, sect_reg;
  logic ack_reg, rej_reg, rdv_reg;
  logic busy_reg, bmn_reg;
  logic [15:0] rdd_reg;

  // ----------------------------------------
  // Acceptance decode
  // ----------------------------------------
  wire take = cmd_valid && !ack_reg && !rej_reg && (state_reg == fsq_pkg::ST_IDLE || state_reg == fsq_pkg::ST_WAIT);
  wire is_byp_op = cmd_op == fsq_pkg::OP_BYP_PROG || cmd_op == fsq_pkg::OP_BYP_RESET;
  wire win_open = sect_reg && coll_reg < 16'(COLL_LIMIT - fsq_pkg::GUARD_CYC);
  wire ok_bypass = !byp_reg || is_byp_op || cmd_op == fsq_pkg::OP_READ
                   || (cmd_op == fsq_pkg::OP_ACCEL_OFF && accel_reg);
  wire ok_ssr = !ssr_reg || !(cmd_op == fsq_pkg::OP_BYP_ENTER || cmd_op == fsq_pkg::OP_ACCEL_ON);
  wire ok_idle = ok_bypass && ok_ssr && (byp_reg || !is_byp_op)
                 && cmd_op != fsq_pkg::OP_SECT_ADD && cmd_op != fsq_pkg::OP_SUSPEND;
  // While busy only window additions, suspend and hardware reset pass; all else would be ignored
  wire ok_wait = (cmd_op == fsq_pkg::OP_SECT_ADD && win_open)
                 || (cmd_op == fsq_pkg::OP_SUSPEND && sect_reg);
  wire ok = cmd_op == fsq_pkg::OP_HWRST || (state_reg == fsq_pkg::ST_IDLE ? ok_idle : ok_wait);
  wire accept = take && ok;
  wire no_cycles = cmd_op == fsq_pkg::OP_ACCEL_ON || cmd_op == fsq_pkg::OP_ACCEL_OFF;
  wire last_idx = idx_reg == fsq_pkg::seq_len(op_reg) - 3'h1;
  wire starts_alg = op_reg inside {fsq_pkg::OP_PROG, fsq_pkg::OP_BYP_PROG, fsq_pkg::OP_CHIP,
                                   fsq_pkg::OP_SECT, fsq_pkg::OP_SECT_ADD};
  // The taking edge already launches the first cycle, so it must see the request's own address and data
  wire [21:0] a_src = accept ? cmd_addr : addr_reg;
  wire [15:0] d_src = accept ? cmd_data : data_reg;
  wire seq_end = state_reg == fsq_pkg::ST_WHIGH && cnt_reg == 16'h0000 && last_idx;
  wire fsq_pkg::fsq_cyc_t cyc_next = fsq_pkg::seq_cycle(op_next, idx_next, BYTE_MODE, a_src, d_src);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    idx_next = idx_reg;
    cnt_next = (cnt_reg != 16'h0000) ? cnt_reg - 16'h0001 : cnt_reg;
    case (state_reg)
      fsq_pkg::ST_IDLE, fsq_pkg::ST_WAIT: begin
        if (accept) begin
          op_next = cmd_op;
          idx_next = 3'h0;
          if (cmd_op == fsq_pkg::OP_HWRST) begin
            state_next = fsq_pkg::ST_HWRST;
            cnt_next = 16'(fsq_pkg::RP_CYC - 1);
          end else if (cmd_op == fsq_pkg::OP_READ) begin
            state_next = fsq_pkg::ST_READ;
            cnt_next = 16'(fsq_pkg::ACC_CYC - 1);
          end else if (!no_cycles) begin
            state_next = fsq_pkg::ST_ADDR;
          end
        end else if (state_reg == fsq_pkg::ST_WAIT && cnt_reg == 16'h0000 && ready_busy_in && !win_open) begin
          state_next = fsq_pkg::ST_IDLE;
        end
      end
      fsq_pkg::ST_ADDR: begin
        // Address settles a cycle before the falling strobe
        state_next = fsq_pkg::ST_WLOW;
        cnt_next = 16'(fsq_pkg::WP_CYC - 1);
      end
      fsq_pkg::ST_WLOW: if (cnt_reg == 16'h0000) begin
        state_next = fsq_pkg::ST_WHIGH;
        cnt_next = 16'(fsq_pkg::WPH_CYC - 1);
      end
      fsq_pkg::ST_WHIGH: if (cnt_reg == 16'h0000) begin
        if (!last_idx) begin
          state_next = fsq_pkg::ST_ADDR;
          idx_next = idx_reg + 3'h1;
        end else if (starts_alg) begin
          state_next = fsq_pkg::ST_WAIT;
          cnt_next = 16'(fsq_pkg::BUSY_CYC);
        end else begin
          state_next = fsq_pkg::ST_IDLE;
        end
      end
      fsq_pkg::ST_READ, fsq_pkg::ST_HWRST: if (cnt_reg == 16'h0000) state_next = fsq_pkg::ST_IDLE;
      default: state_next = fsq_pkg::ST_IDLE;
    endcase
  end

  // Pins follow the next state so every pin comes straight from a flop
  wire strobe_ph = state_next == fsq_pkg::ST_ADDR || state_next == fsq_pkg::ST_WLOW;
  assign fl_next = '{ce_n: !(strobe_ph || state_next == fsq_pkg::ST_READ),
                     we_n: state_next != fsq_pkg::ST_WLOW,
                     oe_n: state_next != fsq_pkg::ST_READ,
                     reset_n: state_next != fsq_pkg::ST_HWRST,
                     addr: (state_next == fsq_pkg::ST_READ) ? a_src : cyc_next.addr,
                     dq_out: cyc_next.data,
                     // Data held through the rising strobe
                     dq_oe: strobe_ph || state_next == fsq_pkg::ST_WHIGH};

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= fsq_pkg::ST_IDLE;
      op_reg <= fsq_pkg::OP_READ;
      idx_reg <= 3'h0;
      cnt_reg <= 16'h0000;
      fl_reg <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, reset_n: 1'b1, addr: 22'h000000, dq_out: 16'h0000, dq_oe: 1'b0};
    end else begin
      state_reg <= state_next;
      op_reg <= op_next;
      idx_reg <= idx_next;
      cnt_reg <= cnt_next;
      fl_reg <= fl_next;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      addr_reg <= 22'h000000;
      data_reg <= 16'h0000;
      ack_reg <= 1'b0;
      rej_reg <= 1'b0;
      rdv_reg <= 1'b0;
      rdd_reg <= 16'h0000;
      busy_reg <= 1'b0;
      bmn_reg <= !BYTE_MODE;
    end else begin
      busy_reg <= state_next == fsq_pkg::ST_WAIT;
      bmn_reg <= !BYTE_MODE;
      ack_reg <= accept;
      rej_reg <= take && !ok;
      if (accept) addr_reg <= cmd_addr;
      if (accept) data_reg <= cmd_data;
      rdv_reg <= state_reg == fsq_pkg::ST_READ && cnt_reg == 16'h0000;
      if (state_reg == fsq_pkg::ST_READ && cnt_reg == 16'h0000) rdd_reg <= dq_in;
    end
  end

  // Mode tracking mirrors the device's decode; a hardware reset drops every mode
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ssr_reg <= 1'b0;
      byp_reg <= 1'b0;
      accel_reg <= 1'b0;
      sect_reg <= 1'b0;
      coll_reg <= 16'h0000;
    end else if (accept && cmd_op == fsq_pkg::OP_HWRST) begin
      ssr_reg <= 1'b0;
      byp_reg <= 1'b0;
      accel_reg <= 1'b0;
      sect_reg <= 1'b0;
    end else begin
      if (accept && cmd_op == fsq_pkg::OP_SSR_ENTER) ssr_reg <= 1'b1;
      if (accept && cmd_op == fsq_pkg::OP_SSR_EXIT) ssr_reg <= 1'b0;
      // Bypass counts once the OP_BYP_ENTER third cycle has been written, or as soon as OP_ACCEL_ON is taken
      if ((seq_end && op_reg == fsq_pkg::OP_BYP_ENTER) || (accept && cmd_op == fsq_pkg::OP_ACCEL_ON)) byp_reg <= 1'b1;
      if (accept && (cmd_op == fsq_pkg::OP_BYP_RESET || cmd_op == fsq_pkg::OP_ACCEL_OFF)) byp_reg <= 1'b0;
      if (accept && cmd_op == fsq_pkg::OP_ACCEL_ON) accel_reg <= 1'b1;
      if (accept && cmd_op == fsq_pkg::OP_ACCEL_OFF) accel_reg <= 1'b0;
      if (accept && cmd_op == fsq_pkg::OP_SUSPEND) sect_reg <= 1'b0;
      else if (state_reg == fsq_pkg::ST_WHIGH && cnt_reg == 16'h0000 && last_idx) begin
        // Window restarts as the high phase of each final write cycle ends
        sect_reg <= op_reg == fsq_pkg::OP_SECT || op_reg == fsq_pkg::OP_SECT_ADD;
        coll_reg <= 16'h0000;
      end else if (state_reg == fsq_pkg::ST_IDLE) sect_reg <= 1'b0;
      else if (coll_reg != 16'(COLL_LIMIT)) coll_reg <= coll_reg + 16'h0001;
    end
  end

  assign cmd_ack = ack_reg;
  assign cmd_rej = rej_reg;
  assign rd_valid = rdv_reg;
  assign rd_data = rdd_reg;
  assign busy = busy_reg;
  assign ssr_mode = ssr_reg;
  assign bypass_mode = byp_reg;
  assign fl = fl_reg;
  assign accel_hv_en = accel_reg;
  assign byte_mode_n = bmn_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_ssr_entry_code: assert property (@(posedge ref_clk) disable iff (rst)
    (state_reg == fsq_pkg::ST_WLOW && op_reg == fsq_pkg::OP_SSR_ENTER && idx_reg == 3'h2)
    |-> fl_reg.dq_out == fsq_pkg::CD_SSR_ENTER && !fl_reg.we_n) else $error("bad region entry code");
  a_prog_four_cycles: assert property (@(posedge ref_clk) disable iff (rst)
    (state_reg == fsq_pkg::ST_WHIGH && cnt_reg == 16'h0000 && op_reg == fsq_pkg::OP_PROG && idx_reg == 3'h3)
    |=> state_reg == fsq_pkg::ST_WAIT) else $error("program did not end after four cycles");
  a_busy_no_cmd: assert property (@(posedge ref_clk) disable iff (rst)
    ($past(state_reg) == fsq_pkg::ST_WAIT && state_reg == fsq_pkg::ST_ADDR)
    |-> op_reg == fsq_pkg::OP_SECT_ADD || op_reg == fsq_pkg::OP_SUSPEND) else $error("command issued while busy");
  a_hwrst_pin_low: assert property (@(posedge ref_clk) disable iff (rst)
    (accept && cmd_op == fsq_pkg::OP_HWRST) |=> !fl_reg.reset_n [*8] ##1 !byp_reg) else $error("reset pulse short");
  a_bypass_code: assert property (@(posedge ref_clk) disable iff (rst)
    (state_reg == fsq_pkg::ST_WLOW && op_reg == fsq_pkg::OP_BYP_ENTER && idx_reg == 3'h2)
    |-> fl_reg.dq_out == fsq_pkg::CD_BYPASS) else $error("bad bypass entry code");
  a_bypass_two_cyc: assert property (@(posedge ref_clk) disable iff (rst)
    (state_reg == fsq_pkg::ST_WLOW && op_reg == fsq_pkg::OP_BYP_PROG)
    |-> fl_reg.dq_out == (idx_reg == 3'h0 ? fsq_pkg::CD_PROG : data_reg)) else $error("bad bypass program cycle");
  a_bypass_only_ops: assert property (@(posedge ref_clk) disable iff (rst)
    (state_reg == fsq_pkg::ST_ADDR && byp_reg)
    |-> op_reg == fsq_pkg::OP_BYP_PROG || op_reg == fsq_pkg::OP_BYP_RESET) else $error("illegal op in bypass");
  a_chip_last_code: assert property (@(posedge ref_clk) disable iff (rst)
    (state_reg == fsq_pkg::ST_WLOW && op_reg == fsq_pkg::OP_CHIP && idx_reg == 3'h5)
    |-> fl_reg.dq_out == fsq_pkg::CD_CHIP) else $error("bad chip erase code");
  a_window_gap: assert property (@(posedge ref_clk) disable iff (rst)
    (seq_end && op_reg == fsq_pkg::OP_SECT_ADD) |-> coll_reg < 16'(COLL_LIMIT)) else $error("sector added too late");
  a_strobe_order: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(fl_reg.we_n) |-> !fl_reg.ce_n && $stable(fl_reg.addr) && fl_reg.dq_oe) else $error("strobe before address");
endmodule : fsq_host

// ### include/fsq_pkg.sv
// Constants, types and sequence tables for the flash command sequencer host.
// Assumes a parallel flash with unlock-cycle command decoding and a ready/busy pin.
package fsq_pkg;
  // ----------------------------------------
  // Widths and bus addresses
  // ----------------------------------------
  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;
  localparam logic [21:0] UNLK_A1_WORD = 22'h000555;
  localparam logic [21:0] UNLK_A2_WORD = 22'h0002AA;
  localparam logic [21:0] UNLK_A1_BYTE = 22'h000AAA;
  localparam logic [21:0] UNLK_A2_BYTE = 22'h000555;
  localparam logic [21:0] ADDR_ANY = 22'h000000;
  // ----------------------------------------
  // Command data codes
  // ----------------------------------------
  localparam logic [15:0] CD_UNLK1 = 16'h00AA;
  localparam logic [15:0] CD_UNLK2 = 16'h0055;
  localparam logic [15:0] CD_PROG = 16'h00A0;
  localparam logic [15:0] CD_BYPASS = 16'h0020;
  localparam logic [15:0] CD_RESET = 16'h00F0;
  localparam logic [15:0] CD_ERASE_SETUP = 16'h0080;
  localparam logic [15:0] CD_CHIP = 16'h0010;
  localparam logic [15:0] CD_SECT = 16'h0030;
  localparam logic [15:0] CD_SSR_ENTER = 16'h0088;
  localparam logic [15:0] CD_SSR_EXIT = 16'h0090;
  localparam logic [15:0] CD_BYP_RESET = 16'h0090;
  localparam logic [15:0] CD_ZERO = 16'h0000;
  localparam logic [15:0] CD_SUSPEND = 16'h00B0;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_NS = 5;
  localparam int T_WP_NS = 30;
  localparam int T_WPH_NS = 20;
  localparam int T_ACC_NS = 70;
  localparam int T_RP_NS = 500;
  localparam int T_BUSY_NS = 90;
  localparam int COLL_US = 80;
  localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WPH_CYC = (T_WPH_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int RP_CYC = (T_RP_NS + CLK_NS - 1) / CLK_NS;
  localparam int BUSY_CYC = (T_BUSY_NS + CLK_NS - 1) / CLK_NS;
  localparam int COLL_CYC = COLL_US * 1000 / CLK_NS;
  // One whole write cycle, kept as margin inside the collection window
  localparam int GUARD_CYC = WP_CYC + WPH_CYC + 1;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [3:0] {
    OP_READ = 4'h0, OP_RESET = 4'h1, OP_PROG = 4'h2, OP_BYP_ENTER = 4'h3,
    OP_BYP_PROG = 4'h4, OP_BYP_RESET = 4'h5, OP_SSR_ENTER = 4'h6, OP_SSR_EXIT = 4'h7,
    OP_CHIP = 4'h8, OP_SECT = 4'h9, OP_SECT_ADD = 4'hA, OP_SUSPEND = 4'hB,
    OP_HWRST = 4'hC, OP_ACCEL_ON = 4'hD, OP_ACCEL_OFF = 4'hE
  } fsq_op_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_ADDR = 3'h1, ST_WLOW = 3'h3, ST_WHIGH = 3'h2,
    ST_WAIT = 3'h6, ST_READ = 3'h4, ST_HWRST = 3'h5
  } fsq_state_t;
  typedef struct packed {
    logic [21:0] addr;
    logic [15:0] data;
  } fsq_cyc_t;
  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic reset_n;
    logic [21:0] addr;
    logic [15:0] dq_out;
    logic dq_oe;
  } fsq_pins_t;
  // ----------------------------------------
  // Sequence tables
  // ----------------------------------------
  function automatic logic [2:0] seq_len(input fsq_op_t op);
    case (op)
      OP_PROG, OP_SSR_EXIT: seq_len = 3'h4;
      OP_BYP_ENTER, OP_SSR_ENTER: seq_len = 3'h3;
      OP_BYP_PROG, OP_BYP_RESET: seq_len = 3'h2;
      OP_CHIP, OP_SECT: seq_len = 3'h6;
      default: seq_len = 3'h1;
    endcase
  endfunction : seq_len

  function automatic fsq_cyc_t seq_cycle(input fsq_op_t op, input logic [2:0] idx, input logic byte_md,
                                         input logic [21:0] a, input logic [15:0] d);
    fsq_cyc_t u1;
    fsq_cyc_t u2;
    fsq_cyc_t c;
    u1 = '{byte_md ? UNLK_A1_BYTE : UNLK_A1_WORD, CD_UNLK1};
    u2 = '{byte_md ? UNLK_A2_BYTE : UNLK_A2_WORD, CD_UNLK2};
    c = (idx == 3'h0 || idx == 3'h3) ? u1 : u2;
    case (op)
      OP_RESET: c = '{ADDR_ANY, CD_RESET};
      OP_PROG: if (idx == 3'h2) c = '{u1.addr, CD_PROG}; else if (idx == 3'h3) c = '{a, d};
      OP_BYP_ENTER: if (idx == 3'h2) c = '{u1.addr, CD_BYPASS};
      OP_SSR_ENTER: if (idx == 3'h2) c = '{u1.addr, CD_SSR_ENTER};
      OP_SSR_EXIT: if (idx == 3'h2) c = '{u1.addr, CD_SSR_EXIT}; else if (idx == 3'h3) c = '{ADDR_ANY, CD_ZERO};
      OP_BYP_PROG: c = (idx == 3'h0) ? '{ADDR_ANY, CD_PROG} : '{a, d};
      OP_BYP_RESET: c = (idx == 3'h0) ? '{ADDR_ANY, CD_BYP_RESET} : '{ADDR_ANY, CD_ZERO};
      OP_CHIP: if (idx == 3'h2) c = '{u1.addr, CD_ERASE_SETUP}; else if (idx == 3'h5) c = '{u1.addr, CD_CHIP};
      OP_SECT: if (idx == 3'h2) c = '{u1.addr, CD_ERASE_SETUP}; else if (idx == 3'h5) c = '{a, CD_SECT};
      OP_SECT_ADD: c = '{a, CD_SECT};
      OP_SUSPEND: c = '{a, CD_SUSPEND};
      default: c = '{a, CD_ZERO};
    endcase
    seq_cycle = c;
  endfunction : seq_cycle
endpackage : fsq_pkg

// ### verif/fsq_flash_model.sv
// Behavioural flash device answering the host sequencer's pins.
// Assumes word mode; a 256-word image stands for the array, sector = addr[7:4].
`timescale 1ns/10ps
module fsq_flash_model #(
  parameter int COLL = 200,
  parameter int PROG_CYC = 40,
  parameter int ERASE_CYC = 300,
  parameter logic [15:0] SERIAL = 16'h5A3C
) (
  // Host pins
  input wire logic ref_clk,
  input wire fsq_pkg::fsq_pins_t fl,
  input wire logic accel_hv_en,
  // Device outputs
  output logic [15:0] dq_in,
  output logic ready_busy_in
);
  logic [15:0] mem [0:255];
  logic [21:0] la = '0;
  logic [15:0] last = '0;
  logic [15:0] pend = '0;
  logic [2:0] step = '0;
  logic pw = 1'b1;
  logic pc = 1'b1;
  logic ssr = 1'b0;
  logic byp = 1'b0;
  int bcnt = 0;
  int coll = 0;
  // Strobes rising together must count as one write cycle
  wire logic wr = !pw && !pc && fl.we_n;
  wire logic [15:0] d = fl.dq_out;
  wire logic [7:0] a = la[7:0];
  wire logic u1 = la == fsq_pkg::UNLK_A1_WORD;
  wire logic u2 = la == fsq_pkg::UNLK_A2_WORD;
  wire logic byp_on = (byp || accel_hv_en) && !ssr;
  assign ready_busy_in = bcnt == 0 && coll == 0;
  // A released bus shows the inverse of its last value, so a stale match cannot pass
  assign dq_in = (!fl.ce_n && !fl.oe_n) ?
    ((ssr && ready_busy_in) ? SERIAL : mem[fl.addr[7:0]]) : ~last;
  initial begin
    foreach (mem[i]) mem[i] = 16'hFFFF;
  end
  always @(posedge ref_clk) begin
    pw <= fl.we_n;
    pc <= fl.ce_n;
    if (!fl.ce_n && !fl.oe_n) last <= dq_in;
    if (pw && !fl.we_n) la <= fl.addr;
    if (!fl.reset_n) begin
      {step, ssr, byp, pend} <= '0;
      bcnt <= 0;
      coll <= 0;
    end else if (bcnt > 0) begin
      bcnt <= bcnt - 1;
      if (bcnt == 1) for (int i = 0; i < 256; i++) if (pend[i / 16]) mem[i] <= 16'hFFFF;
      if (bcnt == 1) pend <= '0;
      if (wr && d == fsq_pkg::CD_SUSPEND && pend != '0) begin
        bcnt <= 0;
        pend <= '0;
      end
    end else if (coll > 0) begin
      coll <= coll - 1;
      if (coll == 1) bcnt <= ERASE_CYC;
      if (wr && d == fsq_pkg::CD_SECT) begin
        coll <= COLL;
        pend[a[7:4]] <= 1'b1;
      end else if (wr) begin
        coll <= 0;
        pend <= '0;
      end
    end else if (wr) begin
      step <= 3'h0;
      case (step)
        3'h0: if (byp_on) begin
          if (d == fsq_pkg::CD_PROG) step <= 3'h6;
          if (d == fsq_pkg::CD_BYP_RESET) step <= 3'h7;
        end else if (u1 && d == fsq_pkg::CD_UNLK1) step <= 3'h1;
        3'h1: if (u2 && d == fsq_pkg::CD_UNLK2) step <= 3'h2;
        3'h2: if (u1) begin
          if (d == fsq_pkg::CD_PROG) step <= 3'h6;
          if (d == fsq_pkg::CD_BYPASS) byp <= !ssr;
          if (d == fsq_pkg::CD_SSR_ENTER) ssr <= 1'b1;
          if (d == fsq_pkg::CD_SSR_EXIT) step <= 3'h7;
          if (d == fsq_pkg::CD_ERASE_SETUP) step <= 3'h3;
        end
        3'h3: if (u1 && d == fsq_pkg::CD_UNLK1) step <= 3'h4;
        3'h4: if (u2 && d == fsq_pkg::CD_UNLK2) step <= 3'h5;
        3'h5: if (u1 && d == fsq_pkg::CD_CHIP) begin
          pend <= '1;
          bcnt <= ERASE_CYC;
        end else if (d == fsq_pkg::CD_SECT) begin
          pend[a[7:4]] <= 1'b1;
          coll <= COLL;
        end
        3'h6: begin
          mem[a] <= mem[a] & d;
          bcnt <= PROG_CYC;
        end
        default: if (d == fsq_pkg::CD_ZERO) {ssr, byp} <= 2'b00;
      endcase
    end
  end
endmodule : fsq_flash_model

// ### verif/fsq_host_tb_top.sv
// Testbench for the flash command sequencer host against the flash model.
// Assumes a shortened 200-cycle erase collection window on both sides.
`timescale 1ns/10ps
module fsq_host_tb_top;
  localparam logic [15:0] SER = 16'h5A3C;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  fsq_pkg::fsq_op_t cmd_op = fsq_pkg::OP_READ;
  logic [21:0] cmd_addr = '0;
  logic [15:0] cmd_data = '0;
  logic cmd_ack, cmd_rej, rd_valid, busy, ssr_mode, bypass_mode, accel_hv_en, byte_mode_n, ready_busy_in;
  logic [15:0] rd_data, dq_in;
  fsq_pkg::fsq_pins_t fl;
  int failures = 0;
  int check_count = 0;
  int cyc = 0;
  int wes = 0;
  logic pwe = 1'b1;
  always #2.5 ref_clk = ~ref_clk;
  fsq_host #(.COLL_LIMIT(200), .BYTE_MODE(1'b0)) u_fsq_host (
    .ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_data(cmd_data), .cmd_ack(cmd_ack), .cmd_rej(cmd_rej), .rd_valid(rd_valid), .rd_data(rd_data),
    .busy(busy), .ssr_mode(ssr_mode), .bypass_mode(bypass_mode), .fl(fl), .dq_in(dq_in),
    .ready_busy_in(ready_busy_in), .accel_hv_en(accel_hv_en), .byte_mode_n(byte_mode_n));
  fsq_flash_model #(.COLL(200), .SERIAL(SER)) u_fsq_flash_model (
    .ref_clk(ref_clk), .fl(fl), .accel_hv_en(accel_hv_en), .dq_in(dq_in), .ready_busy_in(ready_busy_in));
  // Count write cycles on the pins; also cut a hang short
  always @(posedge ref_clk) begin
    pwe <= fl.we_n;
    if (!pwe && fl.we_n) wes <= wes + 1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      $display("ERROR %0t run did not finish", $time);
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  // One user request; ok says whether it must be taken, nw how many flash writes follow
  task automatic op(input fsq_pkg::fsq_op_t o, input logic [21:0] a, input logic [15:0] d,
                    input logic ok, input int nw);
    int n;
    int w0;
    w0 = wes;
    cmd_op <= o;
    cmd_addr <= a;
    cmd_data <= d;
    cmd_valid <= 1'b1;
    @(posedge ref_clk);
    for (n = 0; n < 3000 && cmd_ack !== 1'b1 && cmd_rej !== 1'b1; n++) @(posedge ref_clk);
    cmd_valid <= 1'b0;
    chk(16'({cmd_ack, cmd_rej}), 16'({ok, !ok}), "request answer");
    repeat (12 * nw + 2) @(posedge ref_clk);
    chk(16'(wes - w0), 16'(nw), "write cycle count");
  endtask : op
  task automatic idle();
    int n;
    for (n = 0; n < 2000 && busy !== 1'b0; n++) @(posedge ref_clk);
    chk(busy, 1'b0, "busy stuck");
  endtask : idle
  task automatic rd(input logic [21:0] a, input logic [15:0] e);
    int n;
    op(fsq_pkg::OP_READ, a, 16'h0000, 1'b1, 0);
    for (n = 0; n < 40 && rd_valid !== 1'b1; n++) @(posedge ref_clk);
    chk(rd_valid, 1'b1, "read strobe");
    chk(rd_data, e, "read data");
  endtask : rd
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    chk({fl.ce_n, fl.we_n, fl.oe_n, fl.reset_n, byte_mode_n, fl.dq_oe, busy, ssr_mode, bypass_mode, accel_hv_en},
        10'h3E0, "reset state");
    op(fsq_pkg::OP_PROG, 22'h000010, 16'h1234, 1'b1, 4);
    chk(busy, 1'b1, "busy while programming");
    op(fsq_pkg::OP_RESET, 22'h000000, 16'h0000, 1'b0, 0);
    idle();
    op(fsq_pkg::OP_RESET, 22'h000000, 16'h0000, 1'b1, 1);
    rd(22'h000010, 16'h1234);
    op(fsq_pkg::OP_PROG, 22'h000010, 16'hFFFF, 1'b1, 4);
    idle();
    rd(22'h000010, 16'h1234);
    op(fsq_pkg::OP_PROG, 22'h0000F3, 16'h0F0F, 1'b1, 4);
    idle();
    op(fsq_pkg::OP_PROG, 22'h000005, 16'hA5A5, 1'b1, 4);
    idle();
    rd(22'h0000F3, 16'h0F0F);
    rd(22'h000005, 16'hA5A5);
    op(fsq_pkg::OP_BYP_PROG, 22'h000020, 16'h00A5, 1'b0, 0);
    op(fsq_pkg::OP_BYP_ENTER, 22'h000000, 16'h0000, 1'b1, 3);
    chk(bypass_mode, 1'b1, "bypass entered");
    op(fsq_pkg::OP_PROG, 22'h000020, 16'h0000, 1'b0, 0);
    op(fsq_pkg::OP_BYP_PROG, 22'h000020, 16'h00A5, 1'b1, 2);
    idle();
    op(fsq_pkg::OP_BYP_PROG, 22'h000021, 16'h005A, 1'b1, 2);
    idle();
    op(fsq_pkg::OP_BYP_RESET, 22'h000000, 16'h0000, 1'b1, 2);
    chk(bypass_mode, 1'b0, "bypass left");
    rd(22'h000021, 16'h005A);
    op(fsq_pkg::OP_SSR_ENTER, 22'h000000, 16'h0000, 1'b1, 3);
    chk(ssr_mode, 1'b1, "region entered");
    rd(22'h000010, SER);
    op(fsq_pkg::OP_BYP_ENTER, 22'h000000, 16'h0000, 1'b0, 0);
    op(fsq_pkg::OP_ACCEL_ON, 22'h000000, 16'h0000, 1'b0, 0);
    op(fsq_pkg::OP_SSR_EXIT, 22'h000000, 16'h0000, 1'b1, 4);
    chk(ssr_mode, 1'b0, "region left");
    rd(22'h000010, 16'h1234);
    op(fsq_pkg::OP_ACCEL_ON, 22'h000000, 16'h0000, 1'b1, 0);
    chk({accel_hv_en, bypass_mode}, 2'b11, "accelerate on");
    op(fsq_pkg::OP_BYP_PROG, 22'h000030, 16'h1111, 1'b1, 2);
    idle();
    op(fsq_pkg::OP_ACCEL_OFF, 22'h000000, 16'h0000, 1'b1, 0);
    chk(accel_hv_en, 1'b0, "accelerate off");
    rd(22'h000030, 16'h1111);
    op(fsq_pkg::OP_SECT, 22'h000010, 16'h0000, 1'b1, 6);
    op(fsq_pkg::OP_SECT_ADD, 22'h000030, 16'h0000, 1'b1, 1);
    chk(busy, 1'b1, "busy in window");
    op(fsq_pkg::OP_RESET, 22'h000000, 16'h0000, 1'b0, 0);
    idle();
    rd(22'h000010, 16'hFFFF);
    rd(22'h000030, 16'hFFFF);
    rd(22'h000005, 16'hA5A5);
    op(fsq_pkg::OP_SECT, 22'h000020, 16'h0000, 1'b1, 6);
    op(fsq_pkg::OP_SUSPEND, 22'h000020, 16'h0000, 1'b1, 1);
    idle();
    rd(22'h000021, 16'h005A);
    op(fsq_pkg::OP_CHIP, 22'h000000, 16'h0000, 1'b1, 6);
    op(fsq_pkg::OP_SUSPEND, 22'h000000, 16'h0000, 1'b0, 0);
    idle();
    rd(22'h000005, 16'hFFFF);
    op(fsq_pkg::OP_PROG, 22'h000040, 16'h0000, 1'b1, 4);
    op(fsq_pkg::OP_HWRST, 22'h000000, 16'h0000, 1'b1, 0);
    chk(fl.reset_n, 1'b0, "hardware reset pin");
    repeat (100) @(posedge ref_clk);
    idle();
    op(fsq_pkg::OP_PROG, 22'h000040, 16'h0000, 1'b1, 4);
    idle();
    rd(22'h000040, 16'h0000);
    test_done();
  end
endmodule : fsq_host_tb_top
